/* File: design/ufb_pkg.sv */
package ufb_pkg;

	// Widths of the baud setup
	localparam int             DIV_W      = 19;
	localparam int             MASK_W     = 16;
	localparam int             FRAME_W    = 13;
	localparam int             SLOTS      = 8;

	// Register indices; byte address is four times the index
	localparam logic [7:0]     IDX_DIV0   = 8'h04;
	localparam logic [7:0]     IDX_DIV1   = 8'h05;
	localparam logic [7:0]     IDX_DIV2   = 8'h06;
	localparam logic [7:0]     IDX_TXM_LO = 8'h07;
	localparam logic [7:0]     IDX_TXM_HI = 8'h08;
	localparam logic [7:0]     IDX_RXM_LO = 8'h09;
	localparam logic [7:0]     IDX_RXM_HI = 8'h0a;
	localparam logic [7:0]     IDX_FMT    = 8'h0b;

	// Reset value of every register byte, and the divisor top byte mask
	localparam logic [7:0]     RST_BYTE   = 8'h00;
	localparam logic [7:0]     DIV2_WMASK = 8'h07;

	// Field positions inside frame_layout
	localparam int             FMT_DB_LSB = 0;
	localparam int             FMT_PA_LSB = 4;
	localparam int             FMT_STOP   = 7;

	// Data length codes
	localparam logic [3:0]     DB_7       = 4'h7;
	localparam logic [3:0]     DB_8       = 4'h8;
	localparam logic [3:0]     DB_9       = 4'h9;

	// AHB transfer type for a single transfer
	localparam logic [1:0]     HTRANS_NSEQ = 2'h2;

	// Parity modes
	typedef enum logic [2:0] {
		PAR_NONE  = 3'h0,
		PAR_ODD   = 3'h1,
		PAR_EVEN  = 3'h2,
		PAR_MARK  = 3'h3,
		PAR_SPACE = 3'h4
	} ufb_par_e;

	// One-hot states of both engines
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN  = 2'h2
	} ufb_state_e;

	// Character format, laid out as the frame_layout byte
	typedef struct packed {
		logic       stop_two;
		logic [2:0] parity;
		logic [3:0] dbits;
	} ufb_fmt_s;

endpackage : ufb_pkg

/* File: design/ufb_uart.sv */
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Transmit dither mask is 16 bits in low and high byte registers, RW.
// - Receive dither mask is 16 bits in low and high byte registers, RW.
// - Data length code 0111, 1000, 1001 gives 7, 8, 9 data bits.
// - Parity field bits 6:4 give none, odd, even, mark or space.
// - Nine data bits suppress the parity bit entirely.
// - A 19-bit integer divisor sets the base bit period in clocks.
// - Bit 7 picks one or two stop bits, sent and checked.
module ufb_uart
	import ufb_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// AHB-Lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	// Transmit side
	input  wire logic [8:0]   tx_data,
	input  wire logic         tx_valid,
	output logic              tx_ready,
	// Receive side
	output logic [8:0]        rx_data,
	output logic              rx_valid,
	output logic              rx_frame_err,
	output logic              rx_par_err,
	// Serial pins
	input  wire logic         rx_pin,
	output logic              tx_pin
);

	logic [7:0]         regs_reg [SLOTS];
	logic               wr_pend_reg;
	logic [2:0]         wr_slot_reg;
	logic [31:0]        hrdata_reg;
	ufb_fmt_s           fmt;
	logic [3:0]         dbits_num;
	logic               par_en;
	logic [3:0]         frame_len;
	logic [DIV_W-1:0]   divisor;
	logic [19:0]        div_eff;
	logic [MASK_W-1:0]  tx_mask;
	logic [MASK_W-1:0]  rx_mask;

	// Bus decode of the address phase
	wire        acc      = hsel && hready && htrans == HTRANS_NSEQ;
	wire [7:0]  a_idx    = haddr[9:2];
	wire        a_ok     = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0
		&& a_idx >= IDX_DIV0 && a_idx <= IDX_FMT;
	wire [7:0]  a_off    = a_idx - IDX_DIV0;
	wire [2:0]  a_slot   = a_off[2:0];
	wire        byp      = wr_pend_reg && wr_slot_reg == a_slot;
	wire [7:0]  rd_byte  = !a_ok ? 8'h00 : byp ? hwdata[7:0] & (a_slot == 3'h2
		? DIV2_WMASK : 8'hff) : regs_reg[a_slot];

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// Capture the address phase and return read data one edge later
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wr_pend_reg <= 1'b0;
			wr_slot_reg <= 3'h0;
			hrdata_reg  <= 32'h0;
		end
		else
		begin
			wr_pend_reg <= acc && hwrite && a_ok;
			wr_slot_reg <= a_slot;
			if (acc && !hwrite)
				hrdata_reg <= {24'h0, rd_byte};
		end
	end

	// One byte register per slot, written in the data phase
	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++)
		begin : g_reg
			localparam logic [7:0] WM = (gi == 2) ? DIV2_WMASK : 8'hff;
			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					regs_reg[gi] <= RST_BYTE;
				else if (wr_pend_reg && wr_slot_reg == 3'(gi))
					regs_reg[gi] <= hwdata[7:0] & WM;
			end
		end
	endgenerate

	// Baud and format fields gathered from the register bytes
	assign divisor   = {regs_reg[2][2:0], regs_reg[1], regs_reg[0]};
	assign div_eff   = (divisor == 19'h0) ? 20'h1 : {1'b0, divisor};
	assign tx_mask   = {regs_reg[4], regs_reg[3]};
	assign rx_mask   = {regs_reg[6], regs_reg[5]};
	assign fmt       = ufb_fmt_s'(regs_reg[7]);
	assign dbits_num = fmt.dbits == DB_7 ? 4'd7 :
		fmt.dbits == DB_9 ? 4'd9 : 4'd8;
	assign par_en    = dbits_num != 4'd9 && fmt.parity != PAR_NONE
		&& fmt.parity <= PAR_SPACE;
	assign frame_len = 4'd2 + dbits_num + {3'h0, par_en}
		+ {3'h0, fmt.stop_two};

	// Parity bit over the active data bits
	function automatic logic par_bit(input logic [8:0] d);
		logic x;
		x = 1'b0;
		for (int i = 0; i < 9; i++)
			if (4'(i) < dbits_num)
				x = x ^ d[i];
		case (fmt.parity)
			PAR_ODD:  par_bit = ~x;
			PAR_EVEN: par_bit = x;
			PAR_MARK: par_bit = 1'b1;
			default:  par_bit = 1'b0;
		endcase
	endfunction : par_bit

	// Bit period with one extra clock where the mask bit is set
	function automatic logic [19:0] period(input logic [MASK_W-1:0] m,
		input logic [3:0] i);
		period = div_eff + {19'h0, m[i]};
	endfunction : period

	// Transmit frame: start, data, optional parity, stop bits
	logic [FRAME_W-1:0] tx_frame;
	always_comb
	begin
		tx_frame    = '1;
		tx_frame[0] = 1'b0;
		for (int i = 0; i < 9; i++)
			if (4'(i) < dbits_num)
				tx_frame[i+1] = tx_data[i];
		if (par_en)
			tx_frame[dbits_num+4'd1] = par_bit(tx_data);
	end

	ufb_state_e         tx_st_reg;
	logic [FRAME_W-1:0] tx_sh_reg;
	logic [3:0]         tx_idx_reg;
	logic [19:0]        tx_cnt_reg;
	logic               tx_pin_reg;
	wire                tx_load = tx_valid && tx_st_reg == ST_IDLE;
	wire                tx_end  = tx_cnt_reg == 20'h0;
	wire [3:0]          tx_nidx = tx_idx_reg + 4'd1;

	assign tx_ready = tx_st_reg == ST_IDLE;
	assign tx_pin   = tx_pin_reg;

	// Transmit engine
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			tx_st_reg  <= ST_IDLE;
			tx_sh_reg  <= '1;
			tx_idx_reg <= 4'h0;
			tx_cnt_reg <= 20'h0;
			tx_pin_reg <= 1'b1;
		end
		else
		begin
			case (tx_st_reg)
				ST_IDLE:
					if (tx_load)
					begin
						tx_st_reg  <= ST_RUN;
						tx_sh_reg  <= tx_frame;
						tx_idx_reg <= 4'h0;
						tx_cnt_reg <= period(tx_mask, 4'h0) - 20'h1;
						tx_pin_reg <= 1'b0;
					end
				default:
					if (tx_end)
					begin
						if (tx_nidx == frame_len)
						begin
							tx_st_reg  <= ST_IDLE;
							tx_pin_reg <= 1'b1;
						end
						else
						begin
							tx_idx_reg <= tx_nidx;
							tx_sh_reg  <= {1'b1, tx_sh_reg[FRAME_W-1:1]};
							tx_pin_reg <= tx_sh_reg[1];
							tx_cnt_reg <= period(tx_mask, tx_nidx) - 20'h1;
						end
					end
					else
						tx_cnt_reg <= tx_cnt_reg - 20'h1;
			endcase
		end
	end

	// Receive pin: three stages, change taken when stages two and three agree
	logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_line_reg, rx_prev_reg;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rx_s1_reg   <= 1'b1;
			rx_s2_reg   <= 1'b1;
			rx_s3_reg   <= 1'b1;
			rx_line_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg   <= rx_pin;
			rx_s2_reg   <= rx_s1_reg;
			rx_s3_reg   <= rx_s2_reg;
			rx_prev_reg <= rx_line_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_line_reg <= rx_s3_reg;
		end
	end

	ufb_state_e         rx_st_reg;
	logic [FRAME_W-1:0] rx_bits_reg;
	logic [3:0]         rx_idx_reg;
	logic [19:0]        rx_cnt_reg;
	logic [8:0]         rx_d;
	wire                rx_fall = rx_prev_reg && !rx_line_reg;
	wire                rx_smp  = rx_st_reg == ST_RUN && rx_cnt_reg == 20'h0;
	wire [3:0]          rx_nidx = rx_idx_reg + 4'd1;
	wire                rx_last = rx_nidx == frame_len;
	wire                rx_stop2 = !fmt.stop_two
		|| rx_bits_reg[frame_len-4'd2];

	// Received data bits below the active length
	always_comb
	begin
		rx_d = 9'h0;
		for (int i = 0; i < 9; i++)
			if (4'(i) < dbits_num)
				rx_d[i] = rx_bits_reg[i+1];
	end

	// Receive engine, sampling mid-bit with the receive mask
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rx_st_reg    <= ST_IDLE;
			rx_bits_reg  <= '1;
			rx_idx_reg   <= 4'h0;
			rx_cnt_reg   <= 20'h0;
			rx_data      <= 9'h0;
			rx_valid     <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_par_err   <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			case (rx_st_reg)
				ST_IDLE:
					if (rx_fall)
					begin
						rx_st_reg  <= ST_RUN;
						rx_idx_reg <= 4'h0;
						rx_cnt_reg <= {1'b0, div_eff[19:1]};
					end
				default:
					if (rx_smp)
					begin
						rx_bits_reg[rx_idx_reg] <= rx_line_reg;
						rx_idx_reg <= rx_nidx;
						rx_cnt_reg <= period(rx_mask, rx_nidx) - 20'h1;
						if (rx_idx_reg == 4'h0 && rx_line_reg)
							rx_st_reg <= ST_IDLE;
						else if (rx_last)
						begin
							rx_st_reg    <= ST_IDLE;
							rx_valid     <= 1'b1;
							rx_data      <= rx_d;
							rx_frame_err <= !rx_line_reg || !rx_stop2;
							rx_par_err   <= par_en && par_bit(rx_d)
								!= rx_bits_reg[dbits_num+4'd1];
						end
					end
					else
						rx_cnt_reg <= rx_cnt_reg - 20'h1;
			endcase
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	txm_write_a: assert property (
		acc && hwrite && a_idx == IDX_TXM_LO && a_ok
		|=> ##1 tx_mask[7:0] == $past(hwdata[7:0]))
		else $error("transmit mask low byte not stored");
	rxm_write_a: assert property (
		acc && hwrite && a_idx == IDX_RXM_HI && a_ok
		|=> ##1 rx_mask[15:8] == $past(hwdata[7:0]))
		else $error("receive mask high byte not stored");
	dbits_dec_a: assert property (
		fmt.dbits == DB_7 |-> frame_len - {3'h0, par_en}
		- {3'h0, fmt.stop_two} == 4'd9)
		else $error("seven bit length not decoded");
	odd_parity_a: assert property (
		tx_load && fmt.parity == PAR_ODD && fmt.dbits == DB_8
		|=> ^tx_sh_reg[9:1] == 1'b1)
		else $error("odd parity bit wrong");
	nine_nopar_a: assert property (
		fmt.dbits == DB_9 |-> frame_len == 4'd11 + {3'h0, fmt.stop_two})
		else $error("parity bit added to nine bit data");
	stop_tail_a: assert property (
		tx_st_reg == ST_RUN && tx_end && tx_nidx == frame_len
		|-> tx_pin_reg && (!fmt.stop_two || $past(tx_pin_reg)))
		else $error("stop bits not high");
	div_load_a: assert property (
		tx_load |=> tx_cnt_reg == div_eff - 20'h1 + {19'h0, tx_mask[0]})
		else $error("divisor not used for bit period");
	dither_len_a: assert property (
		tx_st_reg == ST_RUN && tx_end && tx_nidx != frame_len
		|=> tx_cnt_reg == $past(div_eff) - 20'h1
		+ {19'h0, $past(tx_mask[tx_nidx])})
		else $error("dither bit not applied");

endmodule : ufb_uart

/* File: test/ufb_line_end.sv */
`timescale 1ns/1ps
// Far transceiver on the serial line
module ufb_line_end
(
	// Clock
	input  wire logic core_clk,
	// Line
	input  wire logic tx_pin,
	output logic      rx_pin
);
	// Line rests at mark level between frames
	initial rx_pin = 1'b1;

	// Start bit, then n bits LSB first, per cycles each
	task automatic send(input logic [15:0] b, input int n, input int per);
		rx_pin <= 1'b0;
		repeat (per) @(posedge core_clk);
		for (int i = 0; i < n; i++)
		begin
			rx_pin <= b[i];
			repeat (per) @(posedge core_clk);
		end
		rx_pin <= 1'b1;
	endtask : send

	// Find a start bit and sample n bits at their middles
	task automatic grab(output logic [15:0] b, input int n, input int per);
		b = '0;
		while (tx_pin !== 1'b0)
		begin
			@(posedge core_clk);
			#1;
		end
		repeat (per / 2 + per) @(posedge core_clk);
		for (int i = 0; i < n; i++)
		begin
			b[i] = tx_pin;
			repeat (per) @(posedge core_clk);
		end
	endtask : grab
endmodule : ufb_line_end

/* File: test/ufb_bench.sv */
`timescale 1ns/1ps
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin n_fail++; \
	$display("Error %0t: got %h want %h", $time, g, w); end end
module uart_fractional_baud_and_char_format_bench;
	import ufb_pkg::*;
	localparam int PER = 8;
	logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [8:0]  tx_data, rx_data;
	logic        tx_valid, tx_ready, rx_valid, rx_frame_err, rx_par_err;
	logic        rx_pin, tx_pin;
	logic [15:0] got, ex;
	int          n_fail, n_compared, cyc, n, nd, c;
	logic [7:0]  ri[10] = '{IDX_DIV0, IDX_DIV1, IDX_TXM_LO, IDX_TXM_HI,
		IDX_RXM_LO, IDX_RXM_HI, IDX_TXM_LO, IDX_RXM_LO, IDX_DIV2, 8'h03};
	// 115200: divisor 416, index 21 even column; index 31 odd column lows
	logic [7:0]  wv[10] = '{8'ha0, 8'h01, 8'h6d, 8'h0b, 8'h6a, 8'h0b,
		8'hff, 8'hfd, 8'hff, 8'h5a};
	logic [7:0]  ev[10] = '{8'ha0, 8'h01, 8'h6d, 8'h0b, 8'h6a, 8'h0b,
		8'hff, 8'hfd, 8'h07, 8'h00};
	logic [7:0]  fm[6] = '{8'h07, 8'h98, 8'h28, 8'h38, 8'hc8, 8'h19};

	// Clock
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	ufb_uart dut_u(.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
		.rx_par_err(rx_par_err), .rx_pin(rx_pin), .tx_pin(tx_pin));
	ufb_line_end far_u(.core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

	// Verdict
	task automatic summarize();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	// Hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			summarize();
		end
	end

	// One AHB single transfer; read data lands in rd
	task automatic bus(input logic [7:0] idx, input logic wr,
		input logic [7:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= HTRANS_NSEQ;
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, wd};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Hand one character to the transmitter
	task automatic put(input logic [8:0] d);
		@(posedge core_clk);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(posedge core_clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask : put

	// Expected frame after the start bit
	function automatic logic [15:0] frame_of(input logic [8:0] d,
		input ufb_fmt_s f, output int k, output int m);
		logic [15:0] b;
		b = '0;
		m = (f.dbits == DB_7) ? 7 : (f.dbits == DB_9) ? 9 : 8;
		for (int i = 0; i < m; i++)
			b[i] = d[i];
		k = m;
		if (m != 9 && f.parity inside {[3'h1:3'h4]})
		begin
			b[k] = (f.parity == PAR_ODD) ? ~^b : (f.parity == PAR_EVEN) ? ^b :
				(f.parity == PAR_MARK);
			k++;
		end
		b[k] = 1'b1;
		b[k + 1] = f.stop_two;
		k = k + 1 + f.stop_two;
		return b;
	endfunction : frame_of

	// Send a frame to the receiver and check what it reports
	task automatic rx_case(input logic [15:0] b, input logic [1:0] e);
		fork
			far_u.send(b, n, PER);
			do @(posedge core_clk); while (rx_valid !== 1'b1);
		join
		`CHK({rx_par_err, rx_frame_err, rx_data}, {e, 9'(b & ((1 << nd) - 1))})
	endtask : rx_case

	initial
	begin
		{rst_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{tx_data, tx_valid} = '0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(IDX_FMT, 1'b0, 8'h00);
		`CHK(rd, 32'h0)
		// Byte registers read back, reserved bits and holes read zero
		for (int i = 0; i < 10; i++)
		begin
			bus(ri[i], 1'b1, wv[i]);
			bus(ri[i], 1'b0, 8'h00);
			`CHK({hresp, rd}, {1'b0, 24'h0, ev[i]})
			// Same readback also covers the tabulated triple and divisor
		end
		// Plain bit period, no dither
		bus(IDX_DIV0, 1'b1, 8'(PER));
		bus(IDX_DIV1, 1'b1, 8'h00);
		// Top divisor byte too, else the bit period stays huge
		for (int i = IDX_DIV2; i <= IDX_RXM_HI; i++)
			bus(8'(i), 1'b1, 8'h00);
		// Every length, parity mode and stop count, both directions
		for (int i = 0; i < 6; i++)
		begin
			bus(IDX_FMT, 1'b1, fm[i]);
			ex = frame_of(9'h1b3, fm[i], n, nd);
			fork
				far_u.grab(got, n, PER);
				put(9'h1b3);
			join
			`CHK(got, ex)
			rx_case(ex, 2'b00);
		end
		// Wrong parity, then a missing stop bit
		bus(IDX_FMT, 1'b1, 8'h28);
		ex = frame_of(9'h0c3, 8'h28, n, nd);
		rx_case(ex ^ 16'h0100, 2'b10);
		bus(IDX_FMT, 1'b1, 8'h08);
		ex = frame_of(9'h0c3, 8'h08, n, nd);
		rx_case(ex ^ 16'h0100, 2'b01);
		// Dither bit 0 stretches the start bit by one clock
		bus(IDX_TXM_LO, 1'b1, 8'h01);
		fork
			put(9'h001);
			begin
				c = 0;
				while (tx_pin !== 1'b0) @(posedge core_clk);
				while (tx_pin === 1'b0)
				begin
					@(posedge core_clk);
					c++;
				end
			end
		join
		`CHK(c, PER + 1)
		summarize();
	end
endmodule : uart_fractional_baud_and_char_format_bench
